/* File: design/pess_pkg.sv */
// Package for the precise event sampling store: field positions, record layout,
// reset values and state encodings shared by the sampling logic and its buffer.
// Assumes a single 25 MHz core clock and a synchronous active-low reset.
package pess_pkg;
  localparam int unsigned PESS_DATA_W = 32;
  localparam int unsigned PESS_ADDR_W = 32;
  localparam int unsigned PESS_GPR_N = 8;
  // Record: eight general registers, flags, instruction pointer
  localparam int unsigned PESS_REC_WORDS = 10;
  localparam logic [3:0] PESS_REC_LAST = 4'h9;
  localparam logic [3:0] PESS_REC_FLAGS = 4'h8;
  localparam logic [PESS_ADDR_W-1:0] PESS_WORD_BYTES = 32'h0000_0004;
  localparam logic [PESS_ADDR_W-1:0] PESS_REC_BYTES = 32'h0000_0028;
  localparam int unsigned PESS_CNT_W = 40;
  localparam logic [PESS_CNT_W-1:0] PESS_CNT_ONE = 40'h00_0000_0001;
  localparam logic [PESS_CNT_W-1:0] PESS_CNT_MAX = 40'hff_ffff_ffff;
  // Sampling enable register fields
  localparam int unsigned PESS_EN_TAG_BIT = 24;
  localparam int unsigned PESS_EN_SAMPLE_BIT = 25;
  // Feature word bit reporting the store mechanism
  localparam int unsigned PESS_FEAT_STORE_BIT = 21;
  // Counter configuration fields
  localparam logic [3:0] PESS_THRESH_ALL = 4'hf;
  localparam logic [1:0] PESS_AT_NONE = 2'h0;
  localparam logic [1:0] PESS_AT_SINGLE = 2'h1;
  localparam logic [1:0] PESS_AT_BOTH = 2'h2;
  localparam logic [1:0] PESS_AT_ANY = 2'h3;
  // Event classes at retirement; all but PESS_EV_OTHER are counted
  localparam logic [1:0] PESS_EV_OTHER = 2'h0;
  localparam logic [1:0] PESS_EV_EXEC = 2'h1;
  localparam logic [1:0] PESS_EV_FRONT = 2'h2;
  localparam logic [1:0] PESS_EV_REPLAY = 2'h3;
  localparam logic [3:0] PESS_REC_IDX_RST = 4'h0;
  typedef enum logic [1:0] {
    PESS_ST_IDLE = 2'b00,
    PESS_ST_WRITE = 2'b01,
    PESS_ST_RELOAD = 2'b11
  } pess_state_t;
endpackage : pess_pkg

/* File: design/pess_sampler.sv */
// Precise event sampling store: replay tagging gate, sampling counter, record
// writer into a memory buffer, threshold interrupt and clock-tick counter.
// Assumes register values come from the core as plain levels, memory accepts
// record words through a valid/ready port, and buffer fields are set first.
`timescale 1ns/1ps

module pess_sampler
  import pess_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic init_in,
  input wire logic smm_entry_in,
  input wire logic smm_active_in,
  input wire logic machine_check_in,
  input wire logic [31:0] precise_sampling_enable_reg_in,
  input wire logic precise_sampling_absent_flag_in,
  input wire logic store_area_wr_in,
  input wire logic [pess_pkg::PESS_ADDR_W-1:0] store_area_pointer_in,
  input wire logic [pess_pkg::PESS_ADDR_W-1:0] buf_base_in,
  input wire logic [pess_pkg::PESS_ADDR_W-1:0] buf_abs_max_in,
  input wire logic [pess_pkg::PESS_ADDR_W-1:0] buf_int_thresh_in,
  input wire logic index_wr_in,
  input wire logic [pess_pkg::PESS_ADDR_W-1:0] index_wr_val_in,
  input wire logic [pess_pkg::PESS_CNT_W-1:0] counter_reset_in,
  input wire logic counter_load_in,
  input wire logic counter_enable_in,
  input wire logic sampling_counter_sel_in,
  input wire logic [1:0] event_class_in,
  input wire logic replay_uop_in,
  input wire logic replay_matrix_hit_in,
  input wire logic retire_tagged_in,
  input wire logic [pess_pkg::PESS_DATA_W-1:0] gpr_in [pess_pkg::PESS_GPR_N],
  input wire logic [pess_pkg::PESS_DATA_W-1:0] flags_in,
  input wire logic [pess_pkg::PESS_DATA_W-1:0] ip_in,
  input wire logic mt_enable_in,
  input wire logic [1:0] thread_halted_in,
  input wire logic [1:0] thread_sleep_in,
  input wire logic tick_thread_sel_in,
  input wire logic tick_enable_in,
  input wire logic tick_compare_in,
  input wire logic [3:0] tick_threshold_in,
  input wire logic tick_complement_in,
  input wire logic [1:0] tick_active_thread_in,
  input wire logic tick_event_nonnull_in,
  input wire logic mem_ready_in,
  output logic mem_valid_out,
  output logic [pess_pkg::PESS_ADDR_W-1:0] mem_addr_out,
  output logic [pess_pkg::PESS_DATA_W-1:0] mem_data_out,
  output logic [31:0] feature_word_out,
  output logic store_avail_out,
  output logic uop_tag_out,
  output logic sample_interrupt_out,
  output logic buffer_full_out,
  output logic [pess_pkg::PESS_ADDR_W-1:0] index_out,
  output logic [pess_pkg::PESS_ADDR_W-1:0] store_area_out,
  output logic [pess_pkg::PESS_CNT_W-1:0] count_out,
  output logic [pess_pkg::PESS_CNT_W-1:0] tick_count_out,
  output logic counters_powered_out
);
  pess_state_t state_q;
  logic store_on_q;
  logic [PESS_ADDR_W-1:0] area_q;
  logic [PESS_ADDR_W-1:0] index_q;
  logic [PESS_CNT_W-1:0] count_q;
  logic [PESS_CNT_W-1:0] tick_q;
  logic [3:0] word_q;
  logic irq_done_q;
  logic irq_q;
  logic uop_tag_q;
  logic [PESS_DATA_W-1:0] snap_q [PESS_REC_WORDS];
  logic precise_on;
  logic tag_on;
  logic event_ok;
  logic count_ev;
  logic overflow;
  logic full;
  logic wr_valid;
  logic wr_ready;
  logic [PESS_DATA_W-1:0] wr_data;
  logic [PESS_ADDR_W-1:0] wr_addr;
  logic thr_active;
  logic powered;
  logic tick_ev;
  logic any_halt_clear;

  assign feature_word_out = 32'h0000_0001 << PESS_FEAT_STORE_BIT;
  assign store_avail_out = !precise_sampling_absent_flag_in;
  assign precise_on = precise_sampling_enable_reg_in[PESS_EN_TAG_BIT] && store_on_q && store_avail_out;
  assign tag_on = precise_sampling_enable_reg_in[PESS_EN_TAG_BIT]
                  || (!precise_sampling_enable_reg_in[PESS_EN_TAG_BIT]
                      && !precise_sampling_enable_reg_in[PESS_EN_SAMPLE_BIT]);
  assign event_ok = (event_class_in == PESS_EV_EXEC) || (event_class_in == PESS_EV_FRONT)
                    || (event_class_in == PESS_EV_REPLAY);
  assign count_ev = precise_on && event_ok && sampling_counter_sel_in && counter_enable_in
                    && retire_tagged_in && (state_q == PESS_ST_IDLE);
  assign overflow = count_ev && (count_q == PESS_CNT_MAX);
  assign full = (index_q >= buf_abs_max_in);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      uop_tag_q <= 1'b0;
    end else begin
      uop_tag_q <= replay_uop_in && replay_matrix_hit_in && tag_on;
    end
  end
  assign uop_tag_out = uop_tag_q;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in || init_in) begin
      store_on_q <= 1'b0;
    end else if (smm_entry_in || smm_active_in || machine_check_in) begin
      store_on_q <= 1'b0;
    end else if (store_area_wr_in) begin
      store_on_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in || init_in) begin
      area_q <= '0;
    end else if (store_area_wr_in) begin
      area_q <= store_area_pointer_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in || init_in) begin
      state_q <= PESS_ST_IDLE;
      word_q <= PESS_REC_IDX_RST;
    end else begin
      unique case (state_q)
        PESS_ST_IDLE: begin
          if (overflow && !full) begin
            state_q <= PESS_ST_WRITE;
            word_q <= PESS_REC_IDX_RST;
          end
        end
        PESS_ST_WRITE: begin
          if (wr_ready) begin
            if (word_q == PESS_REC_LAST) begin
              state_q <= PESS_ST_RELOAD;
            end
            word_q <= word_q + 4'h1;
          end
        end
        PESS_ST_RELOAD: begin
          state_q <= PESS_ST_IDLE;
        end
        // Unused code recovers to idle rather than stalling the writer
        default: begin
          state_q <= PESS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (overflow && state_q == PESS_ST_IDLE) begin
      for (int i = 0; i < PESS_GPR_N; i++) begin
        snap_q[i] <= gpr_in[i];
      end
      snap_q[PESS_REC_FLAGS] <= flags_in;
      snap_q[PESS_REC_LAST] <= ip_in;
    end
  end

  assign wr_valid = (state_q == PESS_ST_WRITE);
  assign wr_data = snap_q[word_q];
  assign wr_addr = buf_base_in + index_q + (PESS_WORD_BYTES * {28'h0, word_q});

  always_ff @(posedge clk_in) begin
    if (!reset_n_in || init_in) begin
      count_q <= '0;
    end else if (counter_load_in || state_q == PESS_ST_RELOAD || (overflow && full)) begin
      count_q <= counter_reset_in;
    end else if (count_ev && !overflow) begin
      count_q <= count_q + PESS_CNT_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in || init_in) begin
      index_q <= '0;
    end else if (index_wr_in) begin
      index_q <= index_wr_val_in;
    end else if (state_q == PESS_ST_RELOAD) begin
      index_q <= index_q + PESS_REC_BYTES;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in || init_in) begin
      irq_done_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      // Set wins over a same-cycle index rewrite so a first crossing is never lost
      if (!irq_done_q && index_q >= buf_int_thresh_in && state_q == PESS_ST_IDLE) begin
        irq_q <= 1'b1;
        irq_done_q <= 1'b1;
      end else if (index_wr_in) begin
        irq_done_q <= 1'b0;
      end
    end
  end

  assign any_halt_clear = !(thread_halted_in[0] && thread_halted_in[1]);
  assign powered = mt_enable_in ? any_halt_clear : !thread_halted_in[0];
  always_comb begin
    thr_active = 1'b0;
    unique case (tick_active_thread_in)
      PESS_AT_NONE: thr_active = !(!thread_halted_in[0] || !thread_halted_in[1]);
      PESS_AT_SINGLE: thr_active = (!thread_halted_in[0]) ^ (!thread_halted_in[1]);
      PESS_AT_BOTH: thr_active = !thread_halted_in[0] && !thread_halted_in[1];
      PESS_AT_ANY: thr_active = !thread_halted_in[tick_thread_sel_in]
                                && !thread_sleep_in[tick_thread_sel_in];
    endcase
  end
  assign tick_ev = tick_enable_in && tick_event_nonnull_in && powered
                   && ((tick_compare_in && tick_complement_in && tick_threshold_in == PESS_THRESH_ALL)
                       || thr_active);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tick_q <= '0;
    end else if (tick_ev) begin
      tick_q <= tick_q + PESS_CNT_ONE;
    end
  end

  pess_skid_buf u_buf (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(wr_valid),
    .in_ready_out(wr_ready),
    .in_addr_in(wr_addr),
    .in_data_in(wr_data),
    .out_valid_out(mem_valid_out),
    .out_ready_in(mem_ready_in),
    .out_addr_out(mem_addr_out),
    .out_data_out(mem_data_out)
  );

  assign sample_interrupt_out = irq_q;
  assign buffer_full_out = full;
  assign index_out = index_q;
  assign store_area_out = area_q;
  assign count_out = count_q;
  assign tick_count_out = tick_q;
  assign counters_powered_out = powered;

  AST_TAG_GATE: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (replay_uop_in && replay_matrix_hit_in && precise_sampling_enable_reg_in[PESS_EN_TAG_BIT]) |=> uop_tag_out)
    else $error("replayed micro-op not tagged");
  AST_NO_TAG: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!replay_uop_in) |=> !uop_tag_out)
    else $error("tag without replay");
  AST_RECORD: assert property (@(posedge clk_in) disable iff (!reset_n_in || init_in)
    (overflow && !full && state_q == PESS_ST_IDLE) |=> wr_valid)
    else $error("overflow did not start record");
  AST_RELOAD: assert property (@(posedge clk_in) disable iff (!reset_n_in || init_in)
    (state_q == PESS_ST_RELOAD && !counter_load_in) |=> count_q == $past(counter_reset_in))
    else $error("counter not reloaded after record");
  AST_NO_WRAP: assert property (@(posedge clk_in) disable iff (!reset_n_in || init_in)
    (full && state_q == PESS_ST_IDLE) |=> state_q != PESS_ST_WRITE)
    else $error("record written past absolute maximum");
  AST_ADVANCE: assert property (@(posedge clk_in) disable iff (!reset_n_in || init_in)
    (state_q == PESS_ST_RELOAD && !index_wr_in) |=> index_q == $past(index_q) + PESS_REC_BYTES)
    else $error("index not advanced by one record");
  AST_IRQ_ONCE: assert property (@(posedge clk_in) disable iff (!reset_n_in || init_in)
    sample_interrupt_out |=> !sample_interrupt_out)
    else $error("threshold interrupt repeated");
  AST_SMM_OFF: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (smm_entry_in || machine_check_in) |=> !store_on_q)
    else $error("store mechanism not disabled");
  AST_POWER: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mt_enable_in && !thread_halted_in[1]) |-> counters_powered_out)
    else $error("counters powered down with a thread not_halted_subevent");
  AST_EVENT_SET: assert property (@(posedge clk_in) disable iff (!reset_n_in || init_in)
    (event_class_in == PESS_EV_OTHER && !counter_load_in && state_q == PESS_ST_IDLE) |=> $stable(count_q))
    else $error("precise sampling on unsupported event");
endmodule : pess_sampler

/* File: design/pess_skid_buf.sv */
// Two-entry buffer with valid/ready on both sides for record words.
// Assumes the memory port may stall at any time; no word is lost.
`timescale 1ns/1ps
module pess_skid_buf
  import pess_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [pess_pkg::PESS_ADDR_W-1:0] in_addr_in,
  input wire logic [pess_pkg::PESS_DATA_W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [pess_pkg::PESS_ADDR_W-1:0] out_addr_out,
  output logic [pess_pkg::PESS_DATA_W-1:0] out_data_out
);
  logic [PESS_ADDR_W+PESS_DATA_W-1:0] mem_q [2];
  logic rd_ptr_q;
  logic wr_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign in_ready_out = (count_q != 2'h2);
  assign out_valid_out = (count_q != 2'h0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign {out_addr_out, out_data_out} = mem_q[rd_ptr_q];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= {in_addr_in, in_data_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  AST_NO_OVERFLOW: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    count_q <= 2'h2)
    else $error("buffer count beyond two entries");
endmodule : pess_skid_buf

/* File: verification/pess_mem_model.sv */
// Memory sink for sampling record words, able to accept at once or to stall.
// Assumes the sampler holds address and data until ready is seen high.
`timescale 1ns/1ps
module pess_mem_model
  import pess_pkg::*;
(
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic mem_valid_in,
  output logic mem_ready_out,
  input wire logic [pess_pkg::PESS_ADDR_W-1:0] mem_addr_in,
  input wire logic [pess_pkg::PESS_DATA_W-1:0] mem_data_in
);
  logic [PESS_ADDR_W-1:0] addr_log [$];
  logic [PESS_DATA_W-1:0] data_log [$];
  logic [1:0] phase_q;
  initial begin
    mem_ready_out = 1'b1;
    phase_q = 2'h0;
  end
  always @(posedge clk_in) begin
    if (mem_valid_in === 1'b1 && mem_ready_out === 1'b1) begin
      addr_log.push_back(mem_addr_in);
      data_log.push_back(mem_data_in);
    end
    phase_q <= phase_q + 2'h1;
    // Slow mode takes one word in four so the two-entry buffer backs up
    mem_ready_out <= #1 !slow_in || (phase_q == 2'h2);
  end
endmodule : pess_mem_model

/* File: verification/pess_sampler_tb.sv */
// Self-checking bench for the sampler: tagging, record writes, gating, ticks.
// Assumes the memory model accepts words and keeps a log of them.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module pess_sampler_tb;
  import pess_pkg::*;
  logic clk_in, reset_n_in, init_in, smm_entry_in, smm_active_in, machine_check_in;
  logic [31:0] precise_sampling_enable_reg_in;
  logic precise_sampling_absent_flag_in, store_area_wr_in, index_wr_in, counter_load_in, counter_enable_in;
  logic sampling_counter_sel_in, replay_uop_in, replay_matrix_hit_in, retire_tagged_in, mem_ready_in;
  logic [PESS_ADDR_W-1:0] store_area_pointer_in, buf_base_in, buf_abs_max_in, buf_int_thresh_in, index_wr_val_in;
  logic [PESS_CNT_W-1:0] counter_reset_in, count_out, tick_count_out;
  logic [1:0] event_class_in, thread_halted_in, thread_sleep_in, tick_active_thread_in;
  logic [PESS_DATA_W-1:0] gpr_in [PESS_GPR_N];
  logic [PESS_DATA_W-1:0] flags_in, ip_in, mem_data_out;
  logic mt_enable_in, tick_thread_sel_in, tick_enable_in, tick_compare_in, tick_complement_in, tick_event_nonnull_in;
  logic [3:0] tick_threshold_in;
  logic mem_valid_out, store_avail_out, uop_tag_out, sample_interrupt_out, buffer_full_out, counters_powered_out;
  logic [PESS_ADDR_W-1:0] mem_addr_out, index_out, store_area_out;
  logic [31:0] feature_word_out;
  logic slow;
  int fails, compares, irqs;
  logic [1:0] tag_en [3] = '{2'b01, 2'b00, 2'b10};
  logic [2:0] tag_exp = 3'b011;
  logic [1:0] ev_cls [6] = '{PESS_EV_EXEC, PESS_EV_FRONT, PESS_EV_REPLAY, PESS_EV_OTHER, PESS_EV_EXEC, PESS_EV_EXEC};
  logic [5:0] sel_tab = 6'b101111;
  logic [5:0] en_tab = 6'b011111;
  logic [5:0] cnt_tab = 6'b000111;

  pess_sampler u_pess_sampler (.clk_in, .reset_n_in, .init_in, .smm_entry_in, .smm_active_in, .machine_check_in,
    .precise_sampling_enable_reg_in, .precise_sampling_absent_flag_in, .store_area_wr_in, .store_area_pointer_in,
    .buf_base_in, .buf_abs_max_in, .buf_int_thresh_in, .index_wr_in, .index_wr_val_in, .counter_reset_in,
    .counter_load_in, .counter_enable_in, .sampling_counter_sel_in, .event_class_in, .replay_uop_in,
    .replay_matrix_hit_in, .retire_tagged_in, .gpr_in, .flags_in, .ip_in, .mt_enable_in, .thread_halted_in,
    .thread_sleep_in, .tick_thread_sel_in, .tick_enable_in, .tick_compare_in, .tick_threshold_in,
    .tick_complement_in, .tick_active_thread_in, .tick_event_nonnull_in, .mem_ready_in, .mem_valid_out,
    .mem_addr_out, .mem_data_out, .feature_word_out, .store_avail_out, .uop_tag_out, .sample_interrupt_out,
    .buffer_full_out, .index_out, .store_area_out, .count_out, .tick_count_out, .counters_powered_out);
  pess_mem_model u_pess_mem_model (.clk_in(clk_in), .slow_in(slow), .mem_valid_in(mem_valid_out),
    .mem_ready_out(mem_ready_in), .mem_addr_in(mem_addr_out), .mem_data_in(mem_data_out));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (sample_interrupt_out === 1'b1) begin
      irqs++;
    end
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk_in);
    #1 s = 1'b0;
  endtask : pulse
  task automatic events(input int n);
    retire_tagged_in = 1'b1;
    repeat (n) @(posedge clk_in);
    #1 retire_tagged_in = 1'b0;
  endtask : events
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic wait_index(input logic [PESS_ADDR_W-1:0] exp);
    int n;
    n = 0;
    while (index_out !== exp && n < 400) begin
      settle(1);
      n++;
    end
    if (n == 400) begin
      fails++;
      $display("[ERR] %0t index wait timed out", $time);
      stop_test();
    end
  endtask : wait_index
  function automatic logic [PESS_DATA_W-1:0] exp_word(input int w);
    return w < 8 ? gpr_in[w] : (w == 8 ? flags_in : ip_in);
  endfunction : exp_word
  task automatic chk_rec(input int k, input logic [PESS_ADDR_W-1:0] idx);
    int n;
    n = 0;
    // A stalled memory may leave the tail of the record in the two-entry buffer after the index moves
    while (u_pess_mem_model.addr_log.size() < k * 10 + 10 && n < 40) begin
      settle(1);
      n++;
    end
    if (n == 40) begin
      fails++;
      $display("[ERR] %0t record drain timed out", $time);
      stop_test();
    end
    for (int w = 0; w < 10; w++) begin
      `CHK(u_pess_mem_model.addr_log[k * 10 + w], buf_base_in + idx + PESS_WORD_BYTES * 32'(w))
      `CHK(u_pess_mem_model.data_log[k * 10 + w], exp_word(w))
    end
  endtask : chk_rec
  task automatic tick_delta(input logic [PESS_CNT_W-1:0] exp);
    logic [PESS_CNT_W-1:0] t0;
    settle(2);
    t0 = tick_count_out;
    settle(10);
    `CHK(tick_count_out - t0, exp)
  endtask : tick_delta

  initial begin
    {reset_n_in, init_in, smm_entry_in, smm_active_in, machine_check_in, store_area_wr_in, index_wr_in,
      counter_load_in, replay_uop_in, replay_matrix_hit_in, retire_tagged_in, mt_enable_in, tick_thread_sel_in,
      tick_enable_in, tick_compare_in, tick_complement_in, tick_event_nonnull_in, slow} = '0;
    {thread_halted_in, thread_sleep_in, tick_threshold_in, index_wr_val_in} = '0;
    precise_sampling_enable_reg_in = 32'h0000_0000;
    precise_sampling_absent_flag_in = 1'b1;
    store_area_pointer_in = 32'h0000_8000;
    buf_base_in = 32'h0000_1000;
    buf_abs_max_in = 32'h0000_0050;
    buf_int_thresh_in = 32'h0000_0028;
    counter_reset_in = PESS_CNT_MAX - PESS_CNT_ONE;
    counter_enable_in = 1'b1;
    sampling_counter_sel_in = 1'b1;
    event_class_in = PESS_EV_EXEC;
    tick_active_thread_in = PESS_AT_ANY;
    for (int i = 0; i < PESS_GPR_N; i++) begin
      gpr_in[i] = 32'ha5a5_0000 + 32'(i);
    end
    flags_in = 32'h0000_0246;
    ip_in = 32'h0040_1234;
    repeat (5) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    settle(1);
    `CHK(mem_valid_out, 1'b0)
    `CHK({index_out, count_out, sample_interrupt_out}, '0)
    `CHK(feature_word_out[PESS_FEAT_STORE_BIT], 1'b1)
    `CHK(store_avail_out, 1'b0)
    precise_sampling_absent_flag_in = 1'b0;
    settle(1);
    `CHK(store_avail_out, 1'b1)
    // replay type and event chosen before tagging
    for (int i = 0; i < 3; i++) begin
      precise_sampling_enable_reg_in[25:24] = tag_en[i];
      {replay_uop_in, replay_matrix_hit_in} = 2'b11;
      settle(1);
      `CHK(uop_tag_out, tag_exp[i])
    end
    precise_sampling_enable_reg_in[25:24] = 2'b01;
    replay_matrix_hit_in = 1'b0;
    settle(1);
    `CHK(uop_tag_out, 1'b0)
    replay_uop_in = 1'b0;
    // fields, then enable, then counter; counter picked for tagged events
    pulse(index_wr_in);
    precise_sampling_enable_reg_in = 32'h0100_0000;
    pulse(store_area_wr_in);
    `CHK(store_area_out, store_area_pointer_in)
    pulse(counter_load_in);
    `CHK(count_out, counter_reset_in)
    events(2);
    wait_index(32'h0000_0028);
    chk_rec(0, 32'h0000_0000);
    `CHK(count_out, counter_reset_in)
    settle(3);
    `CHK(irqs, 1)
    slow = 1'b1;
    events(2);
    wait_index(32'h0000_0050);
    chk_rec(1, 32'h0000_0028);
    settle(3);
    `CHK(irqs, 1)
    `CHK(buffer_full_out, 1'b1)
    events(2);
    settle(30);
    `CHK(u_pess_mem_model.addr_log.size(), 20)
    `CHK(index_out, 32'h0000_0050)
    `CHK(count_out, counter_reset_in)
    slow = 1'b0;
    pulse(index_wr_in);
    `CHK(buffer_full_out, 1'b0)
    events(2);
    wait_index(32'h0000_0028);
    chk_rec(2, 32'h0000_0000);
    settle(3);
    `CHK(irqs, 2)
    for (int i = 0; i < 6; i++) begin
      event_class_in = ev_cls[i];
      sampling_counter_sel_in = sel_tab[i];
      precise_sampling_enable_reg_in[PESS_EN_TAG_BIT] = en_tab[i];
      pulse(counter_load_in);
      events(1);
      `CHK(count_out, counter_reset_in + 40'(cnt_tab[i]))
    end
    sampling_counter_sel_in = 1'b1;
    precise_sampling_enable_reg_in[PESS_EN_TAG_BIT] = 1'b1;
    for (int i = 0; i < 3; i++) begin
      {smm_active_in, smm_entry_in, machine_check_in} = 3'b001 << i;
      pulse(counter_load_in);
      events(1);
      `CHK(count_out, counter_reset_in)
      {smm_active_in, smm_entry_in, machine_check_in} = 3'b000;
      pulse(store_area_wr_in);
    end
    pulse(counter_load_in);
    events(1);
    `CHK(count_out, PESS_CNT_MAX)
    pulse(init_in);
    `CHK({index_out, count_out}, '0)
    // non-null event selected for free-not_halted_subevent ticks
    tick_event_nonnull_in = 1'b1;
    tick_enable_in = 1'b1;
    {tick_compare_in, tick_complement_in, mt_enable_in} = 3'b111;
    tick_threshold_in = PESS_THRESH_ALL;
    thread_halted_in = 2'b01;
    tick_delta(40'h00_0000_000a);
    `CHK(counters_powered_out, 1'b1)
    thread_halted_in = 2'b11;
    tick_delta(40'h00_0000_0000);
    `CHK(counters_powered_out, 1'b0)
    {tick_compare_in, tick_complement_in} = 2'b00;
    tick_threshold_in = 4'h0;
    thread_halted_in = 2'b00;
    tick_delta(40'h00_0000_000a);
    thread_halted_in = 2'b01;
    tick_delta(40'h00_0000_0000);
    tick_thread_sel_in = 1'b1;
    tick_delta(40'h00_0000_000a);
    thread_sleep_in = 2'b10;
    tick_delta(40'h00_0000_0000);
    thread_sleep_in = 2'b00;
    tick_active_thread_in = PESS_AT_BOTH;
    thread_halted_in = 2'b00;
    tick_delta(40'h00_0000_000a);
    tick_active_thread_in = PESS_AT_SINGLE;
    tick_delta(40'h00_0000_0000);
    thread_halted_in = 2'b10;
    tick_delta(40'h00_0000_000a);
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    fails++;
    $display("[ERR] %0t run timed out", $time);
    stop_test();
  end
endmodule : pess_sampler_tb
